// ---- bench/iie_chk_sva.sv ----
// Checker of the increment execute block, bound to iie_exec.
// Assumes one clock and a synchronous active-low reset.
module iie_chk (
  // Clock and reset
  input logic        core_clk_in,
  input logic        rst_n_in,
  // Instruction side
  input logic        insn_valid_in,
  input logic [11:0] insn_in,
  input logic [4:0]  file_addr_out,
  input logic [7:0]  file_rdata_in,
  input logic        insn_hit_out,
  // Write-back side
  input logic        file_we_out,
  input logic [4:0]  file_waddr_out,
  input logic [7:0]  file_wdata_out,
  input logic        w_we_out,
  input logic [7:0]  w_wdata_out,
  input logic        zero_we_out,
  input logic        zero_val_out,
  input logic        squash_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Bit 8 of the word tells the skip form from the plain one.
  wire       tk  = insn_valid_in && !squash_out && insn_in[11:6] inside {6'h0A, 6'h0F};
  wire [7:0] sum = file_rdata_in + 8'h01;
  // Decode and read address, both seen in the cycle of the word itself.
  hit_decode_a: assert property (insn_hit_out == tk)
    else $error("decode strobe wrong");
  addr_route_a: assert property (file_addr_out == insn_in[4:0])
    else $error("file read address wrong");
  // Anything that is not a taken increment must write nothing.
  idle_quiet_a: assert property (!tk |=> !w_we_out && !file_we_out && !zero_we_out)
    else $error("write without an increment");
  zero_flag_a: assert property (tk && !insn_in[8] |=> zero_we_out &&
    zero_val_out == ($past(sum) == 8'h00)) else $error("zero flag wrong");
  flags_kept_a: assert property (tk && insn_in[8] |=> !zero_we_out)
    else $error("flag written by skip form");
  dest_w_a: assert property (tk && !insn_in[5] |=> w_we_out && !file_we_out &&
    w_wdata_out == $past(sum)) else $error("working register write wrong");
  dest_f_a: assert property (tk && insn_in[5] |=> file_we_out && !w_we_out &&
    file_wdata_out == $past(sum) && file_waddr_out == $past(file_addr_out))
    else $error("file write wrong");
  skip_zero_a: assert property (tk && insn_in[8] && sum == 8'h00 |=>
    squash_out ##1 !squash_out) else $error("skip slot wrong");
  squash_drop_a: assert property (squash_out |=> !w_we_out && !file_we_out)
    else $error("squashed slot executed");
endmodule
bind iie_exec iie_chk u_iie_chk (
  .core_clk_in    (core_clk_in),
  .rst_n_in       (rst_n_in),
  .insn_valid_in  (insn_valid_in),
  .insn_in        (insn_in),
  .file_addr_out  (file_addr_out),
  .file_rdata_in  (file_rdata_in),
  .insn_hit_out   (insn_hit_out),
  .file_we_out    (file_we_out),
  .file_waddr_out (file_waddr_out),
  .file_wdata_out (file_wdata_out),
  .w_we_out       (w_we_out),
  .w_wdata_out    (w_wdata_out),
  .zero_we_out    (zero_we_out),
  .zero_val_out   (zero_val_out),
  .squash_out     (squash_out)
);

// ---- bench/testbench.sv ----
// Self-checking bench of the increment execute block.
// Assumes iie_exec and its checker are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, rst_n = 1'b0, v = 1'b0;
  logic [11:0] insn = 12'h000;
  logic [7:0] rd = 8'h00;
  wire [4:0]  fa, wa;
  wire [7:0]  fd, wd;
  wire        fwe, wwe, zwe, zv, sq, hit;
  int         error_cnt = 0, total_checks = 0, cyc = 0;
  iie_exec u_iie_exec (.core_clk_in(clk), .rst_n_in(rst_n), .insn_valid_in(v), .insn_in(insn),
    .file_addr_out(fa), .file_rdata_in(rd), .file_we_out(fwe), .file_waddr_out(wa),
    .file_wdata_out(fd), .w_we_out(wwe), .w_wdata_out(wd), .zero_we_out(zwe),
    .zero_val_out(zv), .squash_out(sq), .insn_hit_out(hit));
  initial forever #10 clk = ~clk;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Counts a mismatch and reports it on one line.
  task automatic fail(input string msg);
    error_cnt++;
    $display("ERROR at %0t: %s", $time, msg);
  endtask
  // One slot a cycle; results of the previous word are settled on return.
  task automatic slot(input logic vld, input logic [11:0] i, input logic [7:0] d);
    @(posedge clk);
    insn <= i;
    rd <= d;
    v <= vld;
    #1;
  endtask
  // A valid slot, the common case.
  task automatic step(input logic [11:0] i, input logic [7:0] d);
    slot(1'b1, i, d);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Plain form to both destinations, with a wrap to zero first.
  task automatic t_inc;
    step(12'h285, 8'hFF);
    total_checks++;
    if ({hit, fa} !== {1'h1, 5'h05}) fail("plain increment not decoded");
    step(12'h2BF, 8'h41);
    total_checks++;
    if ({wwe, wd, zwe, zv, fwe} !== {1'h1, 8'h00, 1'h1, 1'h1, 1'h0})
      fail("plain increment to W wrong");
    step(12'h000, 8'h00);
    total_checks++;
    if ({fwe, wa, fd, zv, wwe} !== {1'h1, 5'h1F, 8'h42, 1'h0, 1'h0})
      fail("plain increment to file wrong");
    $display("increment test done");
  endtask
  // Skip form: a zero result drops the next slot, a non-zero one does not.
  task automatic t_skip;
    step(12'h3E5, 8'hFF);
    step(12'h285, 8'h01);
    total_checks++;
    if ({sq, hit, fwe, wa, fd, zwe} !== {1'h1, 1'h0, 1'h1, 5'h05, 8'h00, 1'h0})
      fail("skip on zero wrong");
    step(12'h3C0, 8'h10);
    total_checks++;
    if ({sq, fwe, wwe} !== 3'h0) fail("discarded slot executed");
    step(12'h000, 8'h00);
    total_checks++;
    if ({wwe, wd, sq, zwe} !== {1'h1, 8'h11, 1'h0, 1'h0}) fail("skip to W wrong");
    $display("skip test done");
  endtask
  // Idle slots and neighbouring opcodes must write nothing.
  task automatic t_refuse;
    slot(1'b0, 12'h3E5, 8'hFF);
    total_checks++;
    if ({hit, fwe, wwe, zwe} !== 4'h0) fail("other opcode executed");
    step(12'h2E5, 8'hFF);
    total_checks++;
    if ({hit, sq, fwe, wwe, zwe} !== 5'h00) fail("idle slot executed");
    step(12'h3A5, 8'hFF);
    total_checks++;
    if ({hit, fwe, wwe, zwe} !== 4'h0) fail("near opcode executed");
    step(12'h000, 8'h00);
    total_checks++;
    if ({fwe, wwe, zwe} !== 3'h0) fail("near skip opcode executed");
    $display("refuse test done");
  endtask
  // Reset in mid-run clears a pending discard and every registered output.
  task automatic t_reset;
    step(12'h3E5, 8'hFF);
    @(posedge clk);
    rst_n <= 1'b0;
    v <= 1'b0;
    #1;
    total_checks++;
    if ({sq, fwe} !== 2'h3) fail("skip before reset not taken");
    @(posedge clk);
    #1;
    total_checks++;
    if ({sq, fwe, wwe, zwe, zv, wa, fd, wd} !== 26'h0000000) fail("reset left outputs");
    @(posedge clk);
    rst_n <= 1'b1;
    insn <= 12'h285;
    rd <= 8'h7F;
    v <= 1'b1;
    #1;
    total_checks++;
    if ({sq, fwe, wwe, zwe} !== 4'h0) fail("strobe during reset");
    @(posedge clk);
    #1;
    total_checks++;
    if ({wwe, wd, zwe, zv, sq} !== {1'h1, 8'h80, 1'h1, 1'h0, 1'h0})
      fail("first word after reset wrong");
    $display("reset test done");
  endtask
  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  // The run needs about twenty cycles; the ceiling leaves wide margin.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      error_cnt++;
      finish_test;
    end
  end
  // Reset for five cycles, then the scenarios in turn.
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_inc;
    t_skip;
    t_refuse;
    t_reset;
    finish_test;
  end
endmodule

// ---- inc/iie_defs.vh ----
// Constants for the increment instruction execution block.
// Assumes a 12-bit instruction word and a 32-entry file register space.
`ifndef IIE_DEFS_VH
`define IIE_DEFS_VH
// ---------------------------------------------------------------
// Instruction encoding
// ---------------------------------------------------------------
`define IIE_INSN_W      12
`define IIE_OPC_HI      11
`define IIE_OPC_LO      6
`define IIE_OPC_W       6
`define IIE_OPC_INC     6'h0A
`define IIE_OPC_INCSKIP 6'h0F
`define IIE_DEST_BIT    5
`define IIE_FADDR_HI    4
`define IIE_FADDR_LO    0
`define IIE_FADDR_W     5
`define IIE_DATA_W      8
`define IIE_DEST_W      1'h0
`define IIE_DEST_F      1'h1
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define IIE_RST_BIT     1'h0
`endif

// ---- rtl/iie_adder.v ----
// Eight-bit incrementer with a zero detect on the sum.
// Assumes a purely combinational use inside the execute stage.
module iie_adder #(
  parameter WIDTH = 8
) (
  // Operand and result
  input  wire [WIDTH-1:0] operand_in,
  output wire [WIDTH-1:0] sum_out,
  output wire             zero_out
);
  // The carry out is dropped on purpose so the maximum value wraps.
  assign sum_out  = operand_in + {{(WIDTH-1){1'h0}}, 1'h1};
  assign zero_out = (sum_out == {WIDTH{1'h0}});
endmodule

// ---- rtl/iie_exec.v ----
// Decode and execute logic for the two increment instructions of the core.
// Assumes the file register array reads combinationally at file_addr_out,
// that fetch presents one word per cycle while insn_valid_in is high and
// keeps the following word in place while a skip discards it, and that all
// neighbours run on core_clk_in, so no input is synchronised here.
`include "iie_defs.vh"
module iie_exec #(
  parameter DATA_W = `IIE_DATA_W
) (
  // Clock and reset
  input  wire                    core_clk_in,
  input  wire                    rst_n_in,
  // Instruction from fetch
  input  wire                    insn_valid_in,
  input  wire [`IIE_INSN_W-1:0]  insn_in,
  // File register array
  output wire [`IIE_FADDR_W-1:0] file_addr_out,
  input  wire [DATA_W-1:0]       file_rdata_in,
  output wire                    file_we_out,
  output wire [`IIE_FADDR_W-1:0] file_waddr_out,
  output wire [DATA_W-1:0]       file_wdata_out,
  // Working register and status
  output wire                    w_we_out,
  output wire [DATA_W-1:0]       w_wdata_out,
  output wire                    zero_we_out,
  output wire                    zero_val_out,
  // Pipeline control
  output wire                    squash_out,
  output wire                    insn_hit_out
);
  // ---------------------------------------------------------------
  // Local constants
  // ---------------------------------------------------------------
  // Slot states: a normal execute slot, or the discarded slot after a skip.
  localparam ST_EXEC   = 1'h0;
  localparam ST_SQUASH = 1'h1;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  // Fields of the presented word.
  wire [`IIE_OPC_W-1:0]   opc;
  wire                    dest;
  wire [`IIE_FADDR_W-1:0] faddr;
  // Decode strobes.
  wire                    opc_inc;
  wire                    opc_skip;
  wire                    exec_en;
  wire                    is_inc;
  wire                    is_skip;
  wire                    is_hit;
  wire                    to_file;
  wire                    to_w;
  // Incrementer result.
  wire [DATA_W-1:0]       sum;
  wire                    sum_zero;
  // Slot state.
  reg                     state_r;
  reg                     state_nxt;
  // File register write port.
  reg                     file_we_r;
  reg                     file_we_nxt;
  reg  [`IIE_FADDR_W-1:0] file_waddr_r;
  reg  [`IIE_FADDR_W-1:0] file_waddr_nxt;
  reg  [DATA_W-1:0]       file_wdata_r;
  reg  [DATA_W-1:0]       file_wdata_nxt;
  // Working register write port.
  reg                     w_we_r;
  reg                     w_we_nxt;
  reg  [DATA_W-1:0]       w_wdata_r;
  reg  [DATA_W-1:0]       w_wdata_nxt;
  // Zero flag update.
  reg                     zero_we_r;
  reg                     zero_we_nxt;
  reg                     zero_val_r;
  reg                     zero_val_nxt;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Opcode, destination and five-bit file address fields.
  assign opc      = insn_in[`IIE_OPC_HI:`IIE_OPC_LO];
  assign dest     = insn_in[`IIE_DEST_BIT];
  assign faddr    = insn_in[`IIE_FADDR_HI:`IIE_FADDR_LO];

  // Raw opcode matches, before the slot state is taken into account.
  assign opc_inc  = (opc == `IIE_OPC_INC);
  assign opc_skip = (opc == `IIE_OPC_INCSKIP);

  // The discarded slot runs as a no-operation, so nothing in it is decoded.
  // An idle fetch slot is ignored the same way.
  assign exec_en  = insn_valid_in && (state_r == ST_EXEC);
  assign is_inc   = exec_en && opc_inc;
  assign is_skip  = exec_en && opc_skip;
  assign is_hit   = is_inc || is_skip;

  // Both forms route the result by the same destination bit.
  assign to_file  = is_hit && (dest == `IIE_DEST_F);
  assign to_w     = is_hit && (dest == `IIE_DEST_W);

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  // The incrementer drops its carry, so the maximum value wraps to zero.
  iie_adder #(
    .WIDTH      (DATA_W)
  ) u_adder (
    .operand_in (file_rdata_in),
    .sum_out    (sum),
    .zero_out   (sum_zero)
  );

  // ---------------------------------------------------------------
  // Slot state machine
  // ---------------------------------------------------------------
  // A zero skip result discards exactly one already fetched word. The
  // discarded slot can never arm a second discard, because it is never
  // decoded; the cost is that fetch must hold that word for one cycle.
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_EXEC:
      begin
        if (is_skip && sum_zero)
        begin
          state_nxt = ST_SQUASH;
        end
      end
      ST_SQUASH:
      begin
        state_nxt = ST_EXEC;
      end
      default:
      begin
        state_nxt = ST_EXEC;
      end
    endcase
  end

  // Slot state register.
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= ST_EXEC;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Write-back next values
  // ---------------------------------------------------------------
  // Strobes last one cycle; data and address hold until the next write to
  // the same destination, so a consumer may sample them late.
  always @*
  begin
    file_we_nxt    = to_file;
    w_we_nxt       = to_w;
    zero_we_nxt    = is_inc;
    file_waddr_nxt = file_waddr_r;
    file_wdata_nxt = file_wdata_r;
    w_wdata_nxt    = w_wdata_r;
    zero_val_nxt   = zero_val_r;
    if (to_file)
    begin
      file_waddr_nxt = faddr;
      file_wdata_nxt = sum;
    end
    if (to_w)
    begin
      w_wdata_nxt = sum;
    end
    // Only the plain form touches the zero flag.
    if (is_inc)
    begin
      zero_val_nxt = sum_zero;
    end
  end

  // ---------------------------------------------------------------
  // Write-back registers
  // ---------------------------------------------------------------
  // File port. Registering trades one cycle of latency for clean outputs.
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      file_we_r    <= `IIE_RST_BIT;
      file_waddr_r <= {`IIE_FADDR_W{`IIE_RST_BIT}};
      file_wdata_r <= {DATA_W{`IIE_RST_BIT}};
    end
    else
    begin
      file_we_r    <= file_we_nxt;
      file_waddr_r <= file_waddr_nxt;
      file_wdata_r <= file_wdata_nxt;
    end
  end

  // Working register port.
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      w_we_r    <= `IIE_RST_BIT;
      w_wdata_r <= {DATA_W{`IIE_RST_BIT}};
    end
    else
    begin
      w_we_r    <= w_we_nxt;
      w_wdata_r <= w_wdata_nxt;
    end
  end

  // Zero flag port.
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      zero_we_r  <= `IIE_RST_BIT;
      zero_val_r <= `IIE_RST_BIT;
    end
    else
    begin
      zero_we_r  <= zero_we_nxt;
      zero_val_r <= zero_val_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // The read address follows the word at once, so the operand arrives in
  // the same cycle; the hit strobe is a handshake output and stays open.
  assign file_addr_out  = faddr;
  assign insn_hit_out   = is_hit;
  assign squash_out     = (state_r == ST_SQUASH);

  // Data and strobe outputs come straight from flip-flops.
  assign file_we_out    = file_we_r;
  assign file_waddr_out = file_waddr_r;
  assign file_wdata_out = file_wdata_r;
  assign w_we_out       = w_we_r;
  assign w_wdata_out    = w_wdata_r;
  assign zero_we_out    = zero_we_r;
  assign zero_val_out   = zero_val_r;
endmodule
